// File: core/rpsec_pkg.sv
// Shared constants and types for the repeater port address security block
package rpsec_pkg;
  localparam int NPORT    = 17;
  localparam int PORT_W   = 5;
  localparam int DATA_W   = 8;
  localparam int MAC_W    = 48;
  localparam int RADDR_W  = 9;
  localparam int CNT_W    = 4;
  localparam int ERRCNT_W = 16;

  localparam logic [PORT_W-1:0] PORT_LAST = 5'h10;
  localparam logic [CNT_W-1:0]  DA_END    = 4'h6;
  localparam logic [CNT_W-1:0]  SA_END    = 4'hC;
  localparam logic [CNT_W-1:0]  CNT_MAX   = 4'hF;
  localparam int                GROUP_BIT = 40;
  localparam logic [DATA_W-1:0] MASK_BYTE = 8'h55;

  localparam logic [3:0]         OFF_CFG     = 4'h0;
  localparam logic [3:0]         OFF_ADDR_LO = 4'h4;
  localparam logic [3:0]         OFF_ADDR_HI = 4'h8;
  localparam logic [3:0]         OFF_STATUS  = 4'hC;
  localparam logic [RADDR_W-1:0] OFF_ERRCNT  = 9'h110;

  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_INTR     = 2;
  localparam int CFG_EVD      = 3;
  localparam int CFG_ALARM    = 4;
  localparam int CFG_DIS      = 5;
  localparam int ST_DISABLED  = 0;
  localparam int ST_VALID     = 1;
  localparam int ST_INTR      = 2;

  localparam logic [ERRCNT_W-1:0] ERRCNT_RST = 16'h0000;
  localparam logic [MAC_W-1:0]    ADDR_RST   = 48'h0000_0000_0000;

  typedef enum logic [1:0] {
    MODE_ASSIGN,
    MODE_FIRST,
    MODE_CONT
  } rpsec_mode_t;
endpackage : rpsec_pkg

// File: core/rpsec_hdr_if.sv
// Parsed frame header and byte stream shared by parser and port slices
interface rpsec_hdr_if;
  logic                         valid;
  logic                         eof;
  logic                         fcs_err;
  logic [rpsec_pkg::PORT_W-1:0] port;
  logic [rpsec_pkg::DATA_W-1:0] data;
  logic [rpsec_pkg::CNT_W-1:0]  idx;
  logic [rpsec_pkg::MAC_W-1:0]  da;
  logic [rpsec_pkg::MAC_W-1:0]  sa;

  modport src  (output valid, eof, fcs_err, port, data, idx, da, sa);
  modport sink (input  valid, eof, fcs_err, port, data, idx, da, sa);
endinterface : rpsec_hdr_if

// File: core/rpsec_hdr_parse.sv
// Byte counter and destination/source address capture for the frame stream
module rpsec_hdr_parse (
  input  wire logic                         clk_i,
  input  wire logic                         rst_i,
  input  wire logic                         valid_i,
  input  wire logic                         sof_i,
  input  wire logic                         eof_i,
  input  wire logic                         fcs_err_i,
  input  wire logic [rpsec_pkg::PORT_W-1:0] port_i,
  input  wire logic [rpsec_pkg::DATA_W-1:0] data_i,
  rpsec_hdr_if.src                          hdr
);
  typedef struct packed {
    logic [rpsec_pkg::CNT_W-1:0] cnt;
    logic [rpsec_pkg::MAC_W-1:0] da;
    logic [rpsec_pkg::MAC_W-1:0] sa;
  } rpsec_parse_t;

  rpsec_parse_t                s_reg;
  rpsec_parse_t                s_next;
  logic [rpsec_pkg::CNT_W-1:0] cur;

  always_comb
  begin
    cur    = sof_i ? '0 : s_reg.cnt;
    s_next = s_reg;
    if (valid_i)
    begin
      // Header is captured whole, all 48 bits of each address
      if (cur < rpsec_pkg::DA_END)
        s_next.da = {s_reg.da[39:0], data_i};
      else if (cur < rpsec_pkg::SA_END)
        s_next.sa = {s_reg.sa[39:0], data_i};
      s_next.cnt = (cur == rpsec_pkg::CNT_MAX) ? cur : cur + 4'h1;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign hdr.valid   = valid_i;
  assign hdr.eof     = eof_i;
  assign hdr.fcs_err = fcs_err_i;
  assign hdr.port    = port_i;
  assign hdr.data    = data_i;
  assign hdr.idx     = cur;
  assign hdr.da      = s_reg.da;
  assign hdr.sa      = s_reg.sa;
endmodule : rpsec_hdr_parse

// File: core/rpsec_port_slice.sv
// Security state of one port: permitted address, learning, intrusion, mask
module rpsec_port_slice #(
  parameter logic [rpsec_pkg::PORT_W-1:0] PORT_ID = 5'h00
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  rpsec_hdr_if.sink             hdr,
  input  wire logic             cfg_we_i,
  input  wire logic             lo_we_i,
  input  wire logic             hi_we_i,
  input  wire logic             st_we_i,
  input  wire logic [31:0]      wdata_i,
  output logic [3:0][31:0]      regs_o,
  output logic                  enabled_o,
  output logic                  mask_o,
  output logic                  alarm_o,
  output logic                  cerr_o
);
  typedef struct packed {
    rpsec_pkg::rpsec_mode_t      mode;
    logic                        intr_en;
    logic                        evd_en;
    logic                        alarm_en;
    logic                        dis_en;
    logic [rpsec_pkg::MAC_W-1:0] permitted_station_addr;
    logic                        valid;
    logic                        disabled;
    logic                        intr_flag;
    logic                        alarm;
    logic                        cerr;
  } rpsec_slice_t;

  rpsec_slice_t s_reg;
  rpsec_slice_t s_next;
  logic         from_me;
  logic         mism;

  assign from_me = hdr.valid && hdr.eof && (hdr.port == PORT_ID);
  assign mism    = hdr.sa != s_reg.permitted_station_addr;

  always_comb
  begin
    s_next       = s_reg;
    s_next.alarm = 1'b0;
    s_next.cerr  = 1'b0;
    if (cfg_we_i)
    begin
      unique case (wdata_i[1:0])
        2'h1:    s_next.mode = rpsec_pkg::MODE_FIRST;
        2'h2:    s_next.mode = rpsec_pkg::MODE_CONT;
        default: s_next.mode = rpsec_pkg::MODE_ASSIGN;
      endcase
      s_next.intr_en  = wdata_i[rpsec_pkg::CFG_INTR];
      s_next.evd_en   = wdata_i[rpsec_pkg::CFG_EVD];
      s_next.alarm_en = wdata_i[rpsec_pkg::CFG_ALARM];
      s_next.dis_en   = wdata_i[rpsec_pkg::CFG_DIS];
      s_next.valid    = 1'b0;
    end
    if (lo_we_i)
      s_next.permitted_station_addr[31:0] = wdata_i;
    if (hi_we_i)
    begin
      s_next.permitted_station_addr[47:32] = wdata_i[15:0];
      if (s_reg.mode == rpsec_pkg::MODE_ASSIGN)
        s_next.valid = 1'b1;
    end
    if (st_we_i)
    begin
      if (wdata_i[rpsec_pkg::ST_DISABLED])
        s_next.disabled = 1'b0;
      if (wdata_i[rpsec_pkg::ST_INTR])
        s_next.intr_flag = 1'b0;
    end
    // Frame events come last so a set beats a same-cycle clear
    if (from_me)
    begin
      if (hdr.fcs_err)
        s_next.cerr = 1'b1;
      else if (!s_reg.disabled)
      begin
        if (!s_reg.valid)
        begin
          if (s_reg.mode != rpsec_pkg::MODE_ASSIGN)
          begin
            s_next.permitted_station_addr = hdr.sa;
            s_next.valid                  = 1'b1;
          end
        end
        else if (mism)
        begin
          if (s_reg.intr_en)
          begin
            s_next.intr_flag = 1'b1;
            s_next.alarm     = s_reg.alarm_en;
            if (s_reg.mode == rpsec_pkg::MODE_FIRST ||
                (s_reg.mode == rpsec_pkg::MODE_ASSIGN && s_reg.dis_en))
              s_next.disabled = 1'b1;
          end
          if (s_reg.mode == rpsec_pkg::MODE_CONT)
            s_next.permitted_station_addr = hdr.sa;
        end
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s_reg                        <= '0;
      s_reg.mode                   <= rpsec_pkg::MODE_ASSIGN;
      s_reg.permitted_station_addr <= rpsec_pkg::ADDR_RST;
    end
    else
      s_reg <= s_next;
  end

  // Unicast to another station is masked; group frames pass
  assign mask_o = s_reg.evd_en && s_reg.valid && !hdr.da[rpsec_pkg::GROUP_BIT]
                  && (hdr.da != s_reg.permitted_station_addr);
  assign enabled_o = !s_reg.disabled;
  assign alarm_o   = s_reg.alarm;
  assign cerr_o    = s_reg.cerr;

  always_comb
  begin
    regs_o       = '0;
    regs_o[0][1:0]                  = s_reg.mode;
    regs_o[0][rpsec_pkg::CFG_INTR]  = s_reg.intr_en;
    regs_o[0][rpsec_pkg::CFG_EVD]   = s_reg.evd_en;
    regs_o[0][rpsec_pkg::CFG_ALARM] = s_reg.alarm_en;
    regs_o[0][rpsec_pkg::CFG_DIS]   = s_reg.dis_en;
    regs_o[1]       = s_reg.permitted_station_addr[31:0];
    regs_o[2][15:0] = s_reg.permitted_station_addr[47:32];
    regs_o[3][rpsec_pkg::ST_DISABLED] = s_reg.disabled;
    regs_o[3][rpsec_pkg::ST_VALID]    = s_reg.valid;
    regs_o[3][rpsec_pkg::ST_INTR]     = s_reg.intr_flag;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence held_off_s;
    s_reg.disabled ##1 s_reg.disabled;
  endsequence

  first_lock_a: assert property (
    s_reg.mode == rpsec_pkg::MODE_FIRST && s_reg.valid && !cfg_we_i
    && !lo_we_i && !hi_we_i |=> $stable(s_reg.permitted_station_addr))
    else $error("first heard address changed");
  cont_nodis_a: assert property (
    s_reg.mode == rpsec_pkg::MODE_CONT && !s_reg.disabled |=> !s_reg.disabled)
    else $error("learn continuous port disabled");
  fcs_ignore_a: assert property (
    from_me && hdr.fcs_err && !st_we_i
    |=> $stable(s_reg.disabled) && !s_reg.alarm && s_reg.cerr)
    else $error("errored frame treated as intrusion");
  intr_off_a: assert property (
    from_me && !hdr.fcs_err && !s_reg.disabled && s_reg.valid && mism
    && s_reg.intr_en && s_reg.mode == rpsec_pkg::MODE_FIRST && !st_we_i
    ##1 !st_we_i |-> held_off_s)
    else $error("intruder did not disable port");
  addr_learn_a: assert property (
    from_me && !hdr.fcs_err && !s_reg.disabled && !s_reg.valid && !cfg_we_i
    && s_reg.mode != rpsec_pkg::MODE_ASSIGN
    |=> s_reg.valid && s_reg.permitted_station_addr == $past(hdr.sa))
    else $error("address not learned");
  assign_valid_a: assert property (
    hi_we_i && !cfg_we_i && s_reg.mode == rpsec_pkg::MODE_ASSIGN
    |=> s_reg.valid)
    else $error("assigned address not in force");
endmodule : rpsec_port_slice

// File: core/rpsec_top.sv
// Repeater port address security: register port, slices and transmit masking
//
// Operation
// - Every twisted-pair port and the AUI port have their own security.
// - Each port holds one permitted address used for all comparisons.
// - With intruder checking on, every inbound source address is compared.
// - Source mismatch is an intrusion: disable port, alarm, or both.
// - With eavesdrop protection on, matching destination passes unchanged.
// - Unicast frames to another station get a meaningless payload.
// - Broadcast and multicast frames go to every port unmodified.
// - An assigned address puts protection in force at once.
// - Learning modes protect only after a frame arrives; source is learned.
// - First-heard mode latches the first source address for good.
// - First-heard mode disables the port on intrusion.
// - Learn-continuous mode replaces the address with each new station.
// - Learn-continuous never disables; masking and alarms still work.
// - A frame with a check error is counted, never a violation.
// - A disabled port stays off until software re-enables it.
// - Masked payload is alternating ones and zeros, same length.
module rpsec_top (
  input  wire logic                                 CLK_I,
  input  wire logic                                 RST_I,
  input  wire logic                                 RX_VALID_I,
  input  wire logic                                 RX_SOF_I,
  input  wire logic                                 RX_EOF_I,
  input  wire logic                                 RX_FCS_ERR_I,
  input  wire logic [rpsec_pkg::PORT_W-1:0]         RX_PORT_I,
  input  wire logic [rpsec_pkg::DATA_W-1:0]         RX_DATA_I,
  input  wire logic [rpsec_pkg::RADDR_W-1:0]        REG_ADDR_I,
  input  wire logic [31:0]                          REG_WDATA_I,
  input  wire logic                                 REG_WR_I,
  input  wire logic                                 REG_RD_I,
  output logic      [31:0]                          REG_RDATA_O,
  output logic      [rpsec_pkg::NPORT-1:0]          TX_VALID_O,
  output logic      [rpsec_pkg::NPORT*8-1:0]        TX_DATA_O,
  output logic      [rpsec_pkg::NPORT-1:0]          PORT_ENABLE_O,
  output logic                                      ALARM_O,
  output logic      [rpsec_pkg::PORT_W-1:0]         ALARM_PORT_O,
  output logic                                      CHECK_ERR_O
);
  typedef struct packed {
    logic [31:0]                       rdata;
    logic [rpsec_pkg::NPORT-1:0]       tx_valid;
    logic [rpsec_pkg::NPORT*8-1:0]     tx_data;
    logic [rpsec_pkg::NPORT-1:0]       port_en;
    logic                              alarm;
    logic [rpsec_pkg::PORT_W-1:0]      alarm_port;
    logic                              cerr;
    logic [rpsec_pkg::ERRCNT_W-1:0]    errcnt;
  } rpsec_top_t;

  rpsec_top_t                        s_reg;
  rpsec_top_t                        s_next;
  logic [rpsec_pkg::NPORT-1:0][3:0][31:0] regs;
  logic [rpsec_pkg::NPORT-1:0]       enabled;
  logic [rpsec_pkg::NPORT-1:0]       mask;
  logic [rpsec_pkg::NPORT-1:0]       alarm_v;
  logic [rpsec_pkg::NPORT-1:0]       cerr_v;
  logic [rpsec_pkg::NPORT-1:0]       cfg_we;
  logic [rpsec_pkg::NPORT-1:0]       lo_we;
  logic [rpsec_pkg::NPORT-1:0]       hi_we;
  logic [rpsec_pkg::NPORT-1:0]       st_we;
  logic [rpsec_pkg::PORT_W-1:0]      sel;
  logic [3:0]                        off;
  logic                              src_ok;
  logic                              body;

  rpsec_hdr_if hdr ();

  rpsec_hdr_parse u_parse (
    .clk_i     (CLK_I),
    .rst_i     (RST_I),
    .valid_i   (RX_VALID_I),
    .sof_i     (RX_SOF_I),
    .eof_i     (RX_EOF_I),
    .fcs_err_i (RX_FCS_ERR_I),
    .port_i    (RX_PORT_I),
    .data_i    (RX_DATA_I),
    .hdr       (hdr.src)
  );

  assign sel = REG_ADDR_I[8:4];
  assign off = REG_ADDR_I[3:0];

  // Sixteen twisted-pair ports and the AUI port, each independent
  genvar g;
  generate
    for (g = 0; g < rpsec_pkg::NPORT; g++)
    begin : g_port
      assign cfg_we[g] = REG_WR_I && sel == 5'(g) && off == rpsec_pkg::OFF_CFG;
      assign lo_we[g]  = REG_WR_I && sel == 5'(g)
                         && off == rpsec_pkg::OFF_ADDR_LO;
      assign hi_we[g]  = REG_WR_I && sel == 5'(g)
                         && off == rpsec_pkg::OFF_ADDR_HI;
      assign st_we[g]  = REG_WR_I && sel == 5'(g)
                         && off == rpsec_pkg::OFF_STATUS;

      rpsec_port_slice #(
        .PORT_ID (5'(g))
      ) u_slice (
        .clk_i     (CLK_I),
        .rst_i     (RST_I),
        .hdr       (hdr.sink),
        .cfg_we_i  (cfg_we[g]),
        .lo_we_i   (lo_we[g]),
        .hi_we_i   (hi_we[g]),
        .st_we_i   (st_we[g]),
        .wdata_i   (REG_WDATA_I),
        .regs_o    (regs[g]),
        .enabled_o (enabled[g]),
        .mask_o    (mask[g]),
        .alarm_o   (alarm_v[g]),
        .cerr_o    (cerr_v[g])
      );
    end
  endgenerate

  // Frames from a disabled or unknown port are not repeated
  assign src_ok = hdr.port <= rpsec_pkg::PORT_LAST && enabled[hdr.port];
  // Bytes after the destination address may be masked
  assign body   = hdr.idx >= rpsec_pkg::DA_END;

  always_comb
  begin
    s_next            = s_reg;
    s_next.rdata      = '0;
    s_next.alarm      = |alarm_v;
    s_next.alarm_port = '0;
    s_next.cerr       = |cerr_v;
    s_next.port_en    = enabled;
    for (int p = 0; p < rpsec_pkg::NPORT; p++)
    begin
      if (alarm_v[p])
        s_next.alarm_port = 5'(p);
    end
    if (|cerr_v)
      s_next.errcnt = s_reg.errcnt + 16'h0001;

    if (REG_RD_I)
    begin
      if (REG_ADDR_I == rpsec_pkg::OFF_ERRCNT)
        s_next.rdata = {16'h0000, s_reg.errcnt};
      else if (sel <= rpsec_pkg::PORT_LAST && off[1:0] == 2'h0)
        s_next.rdata = regs[sel][off[3:2]];
    end

    for (int q = 0; q < rpsec_pkg::NPORT; q++)
    begin
      s_next.tx_valid[q] = hdr.valid && src_ok && enabled[q]
                           && hdr.port != 5'(q);
      // Length and carrier kept, only content replaced
      if (mask[q] && body)
        s_next.tx_data[q*8 +: 8] = rpsec_pkg::MASK_BYTE;
      else
        s_next.tx_data[q*8 +: 8] = hdr.data;
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      s_reg         <= '0;
      s_reg.port_en <= '1;
      s_reg.errcnt  <= rpsec_pkg::ERRCNT_RST;
    end
    else
      s_reg <= s_next;
  end

  assign REG_RDATA_O   = s_reg.rdata;
  assign TX_VALID_O    = s_reg.tx_valid;
  assign TX_DATA_O     = s_reg.tx_data;
  assign PORT_ENABLE_O = s_reg.port_en;
  assign ALARM_O       = s_reg.alarm;
  assign ALARM_PORT_O  = s_reg.alarm_port;
  assign CHECK_ERR_O   = s_reg.cerr;

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  sequence port0_masked_s;
    hdr.valid && src_ok && enabled[0] && hdr.port != 5'h00 && body;
  endsequence

  tx_mask_a: assert property (
    port0_masked_s and mask[0]
    |=> TX_VALID_O[0] && TX_DATA_O[7:0] == rpsec_pkg::MASK_BYTE)
    else $error("masked byte not alternating pattern");
  group_pass_a: assert property (
    port0_masked_s and hdr.da[rpsec_pkg::GROUP_BIT]
    |=> TX_DATA_O[7:0] == $past(hdr.data))
    else $error("group frame altered");
  src_block_a: assert property (
    hdr.valid && hdr.port <= rpsec_pkg::PORT_LAST && !enabled[hdr.port]
    |=> TX_VALID_O == '0)
    else $error("disabled port frame repeated");
  rd_latency_a: assert property (
    REG_RD_I && REG_ADDR_I == rpsec_pkg::OFF_ERRCNT
    |=> REG_RDATA_O == {16'h0000, $past(s_reg.errcnt)})
    else $error("counter read wrong");
  rd_idle_a: assert property (
    !REG_RD_I |=> REG_RDATA_O == 32'h0000_0000)
    else $error("read data outside read slot");
  errcnt_step_a: assert property (
    |cerr_v |=> s_reg.errcnt == $past(s_reg.errcnt) + 16'h0001 ##1 1'b1)
    else $error("check error not counted");
endmodule : rpsec_top

// File: verification/rpsec_station.sv
// End-node station model that feeds each frame into the repeater port named in the call
module rpsec_station (
  input  wire logic                         clk_i,
  output logic                              valid_o,
  output logic                              sof_o,
  output logic                              eof_o,
  output logic                              fcs_err_o,
  output logic [rpsec_pkg::PORT_W-1:0]      port_o,
  output logic [rpsec_pkg::DATA_W-1:0]      data_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    valid_o   = 1'b0;
    sof_o     = 1'b0;
    eof_o     = 1'b0;
    fcs_err_o = 1'b0;
    port_o    = 5'h00;
    data_o    = 8'hA5;
  end

  // Sixteen byte frame, address bytes most significant first
  task automatic send(input logic [4:0] p, input logic [127:0] f,
                      input logic fe);
    for (int i = 0; i < 16; i++)
    begin
      @(posedge clk_i);
      valid_o   <= 1'b1;
      sof_o     <= (i == 0);
      eof_o     <= (i == 15);
      fcs_err_o <= fe && (i == 15);
      port_o    <= p;
      data_o    <= f[127-8*i -: 8];
    end
    @(posedge clk_i);
    valid_o   <= 1'b0;
    sof_o     <= 1'b0;
    eof_o     <= 1'b0;
    fcs_err_o <= 1'b0;
    // Idle line shows no stale byte
    data_o    <= ~f[7:0];
  endtask : send
endmodule : rpsec_station

// File: verification/testbench.sv
// Self-checking bench for the repeater port address security block
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [47:0] A  = 48'h0A1B_2C3D_4E50;
  localparam logic [47:0] B  = 48'h0C00_0000_0B0B;
  localparam logic [47:0] C  = 48'h0E00_0000_0C0C;
  localparam logic [47:0] D  = 48'h0200_0000_0D0D;
  localparam logic [47:0] BC = 48'hFFFF_FFFF_FFFF;
  localparam logic [47:0] MC = 48'h0100_5E00_0001;
  localparam logic [31:0] INTR = 32'h1 << rpsec_pkg::CFG_INTR;
  localparam logic [31:0] EVD  = 32'h1 << rpsec_pkg::CFG_EVD;
  localparam logic [31:0] ALM  = 32'h1 << rpsec_pkg::CFG_ALARM;
  localparam logic [31:0] DIS  = 32'h1 << rpsec_pkg::CFG_DIS;
  localparam logic [31:0] VLD  = 32'h1 << rpsec_pkg::ST_VALID;

  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        rx_valid, rx_sof, rx_eof, rx_fcs;
  logic [4:0]  rx_port;
  logic [7:0]  rx_data;
  logic [8:0]  reg_addr = 9'h000;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [16:0] tx_valid, en;
  logic [135:0] tx_data;
  logic        alarm, cerr;
  logic [4:0]  alarm_port;
  int          errors = 0;
  int          checks_done = 0;
  int          seed = 47007;
  int          watch = 0;
  int          cerr_seen = 0;
  logic        rd_pend = 1'b0;
  logic [31:0] rd_q[$];
  logic [7:0]  tx_q[$];
  logic [4:0]  al_q[$];

  always #5 clk = ~clk;

  rpsec_station i_sta (.clk_i(clk), .valid_o(rx_valid), .sof_o(rx_sof),
    .eof_o(rx_eof), .fcs_err_o(rx_fcs), .port_o(rx_port), .data_o(rx_data));

  rpsec_top i_dut (.CLK_I(clk), .RST_I(rst), .RX_VALID_I(rx_valid),
    .RX_SOF_I(rx_sof), .RX_EOF_I(rx_eof), .RX_FCS_ERR_I(rx_fcs),
    .RX_PORT_I(rx_port), .RX_DATA_I(rx_data), .REG_ADDR_I(reg_addr),
    .REG_WDATA_I(reg_wdata), .REG_WR_I(reg_wr), .REG_RD_I(reg_rd),
    .REG_RDATA_O(reg_rdata), .TX_VALID_O(tx_valid), .TX_DATA_O(tx_data),
    .PORT_ENABLE_O(en), .ALARM_O(alarm), .ALARM_PORT_O(alarm_port),
    .CHECK_ERR_O(cerr));

  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic stop_test();
    $display("errors %0d checks_done %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : stop_test

  function automatic logic [8:0] ra(input int p, input logic [3:0] off);
    return 9'(p * 16) | 9'(off);
  endfunction : ra

  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [8:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    rd_q.push_back(exp);
    @(posedge clk);
    reg_rd   <= 1'b0;
  endtask : rd

  // Notes the bytes the watched port should carry, then sends the frame
  task automatic frame(input int src, input int w, input logic [47:0] da,
                       input logic [47:0] sa, input logic fe,
                       input logic msk, input logic rep);
    logic [127:0] f;
    f = {da, sa, 32'($random(seed))};
    watch = w;
    for (int i = 0; i < 16 && rep; i++)
      tx_q.push_back((msk && i >= 6) ? rpsec_pkg::MASK_BYTE
                                     : f[127-8*i -: 8]);
    i_sta.send(5'(src), f, fe);
    repeat (4) @(posedge clk);
  endtask : frame

  always @(negedge clk)
  begin
    if (rd_pend)
      chk("read data", reg_rdata,
          rd_q.size() ? rd_q.pop_front() : 32'hDEAD_0000);
    rd_pend = reg_rd;
    if (tx_valid[watch])
      chk("tx byte", 32'(tx_data[watch*8 +: 8]),
          tx_q.size() ? 32'(tx_q.pop_front()) : 32'h100);
    if (alarm)
      chk("alarm port", 32'(alarm_port),
          al_q.size() ? 32'(al_q.pop_front()) : 32'hFF);
    if (cerr)
      cerr_seen++;
  end

  initial
  begin
    #200000;
    errors++;
    stop_test();
  end

  initial
  begin
    repeat (20) @(posedge clk);
    chk("enables in reset", 32'(en), 32'h0001_FFFF);
    rst <= 1'b0;
    rd(ra(0, rpsec_pkg::OFF_CFG), 32'h0);
    rd(ra(0, rpsec_pkg::OFF_STATUS), 32'h0);
    rd(ra(16, rpsec_pkg::OFF_ADDR_LO), 32'h0);
    rd(9'h1F0, 32'h0);
    rd(rpsec_pkg::OFF_ERRCNT, 32'h0);
    // Assigned address on port 1, all protections on
    wr(ra(1, rpsec_pkg::OFF_CFG), INTR | EVD | ALM | DIS);
    wr(ra(1, rpsec_pkg::OFF_ADDR_LO), A[31:0]);
    wr(ra(1, rpsec_pkg::OFF_ADDR_HI), 32'(A[47:32]));
    rd(ra(1, rpsec_pkg::OFF_STATUS), VLD);
    frame(2, 1, BC, C, 1'b0, 1'b0, 1'b1);
    frame(2, 1, MC, C, 1'b0, 1'b0, 1'b1);
    frame(2, 1, A, C, 1'b0, 1'b0, 1'b1);
    frame(2, 1, B, C, 1'b0, 1'b1, 1'b1);
    frame(2, 1, A ^ 48'h1, C, 1'b0, 1'b1, 1'b1);
    frame(1, 2, BC, A, 1'b0, 1'b0, 1'b1);
    al_q.push_back(5'h01);
    frame(1, 2, BC, B, 1'b0, 1'b0, 1'b1);
    chk("port 1 enable", 32'(en[1]), 32'h0);
    frame(1, 2, BC, A, 1'b0, 1'b0, 1'b0);
    chk("port 1 stays off", 32'(en[1]), 32'h0);
    rd(ra(1, rpsec_pkg::OFF_STATUS), 32'h7);
    wr(ra(1, rpsec_pkg::OFF_STATUS), 32'h5);
    rd(ra(1, rpsec_pkg::OFF_STATUS), VLD);
    chk("port 1 back on", 32'(en[1]), 32'h1);
    // Corrupted frame with foreign source is only a check error
    frame(1, 2, BC, B, 1'b1, 1'b0, 1'b1);
    chk("port 1 after bad frame", 32'(en[1]), 32'h1);
    rd(rpsec_pkg::OFF_ERRCNT, 32'h1);
    // First-heard learning on port 3
    wr(ra(3, rpsec_pkg::OFF_CFG), 32'(rpsec_pkg::MODE_FIRST) | INTR);
    rd(ra(3, rpsec_pkg::OFF_STATUS), 32'h0);
    frame(3, 2, BC, C, 1'b0, 1'b0, 1'b1);
    rd(ra(3, rpsec_pkg::OFF_STATUS), VLD);
    frame(3, 2, BC, D, 1'b0, 1'b0, 1'b1);
    chk("port 3 enable", 32'(en[3]), 32'h0);
    rd(ra(3, rpsec_pkg::OFF_ADDR_LO), C[31:0]);
    // Learn-continuous on the AUI port
    wr(ra(16, rpsec_pkg::OFF_CFG),
       32'(rpsec_pkg::MODE_CONT) | INTR | ALM | DIS);
    frame(16, 2, BC, C, 1'b0, 1'b0, 1'b1);
    al_q.push_back(5'h10);
    frame(16, 2, BC, D, 1'b0, 1'b0, 1'b1);
    chk("aui enable", 32'(en[16]), 32'h1);
    rd(ra(16, rpsec_pkg::OFF_ADDR_LO), D[31:0]);
    rd(ra(16, rpsec_pkg::OFF_ADDR_HI), 32'(D[47:32]));
    chk("port 2 enable", 32'(en[2]), 32'h1);
    // Port 0: mode code 3 acts as assigned, alarm only, no auto disable
    wr(ra(0, rpsec_pkg::OFF_CFG), 32'h3 | INTR | EVD | ALM);
    wr(ra(0, rpsec_pkg::OFF_ADDR_LO), B[31:0]);
    wr(ra(0, rpsec_pkg::OFF_ADDR_HI), 32'(B[47:32]));
    rd(ra(0, rpsec_pkg::OFF_CFG), INTR | EVD | ALM);
    rd(ra(0, rpsec_pkg::OFF_STATUS), VLD);
    frame(2, 0, C, D, 1'b0, 1'b1, 1'b1);
    frame(2, 0, MC, D, 1'b0, 1'b0, 1'b1);
    al_q.push_back(5'h00);
    frame(0, 2, BC, C, 1'b0, 1'b0, 1'b1);
    chk("port 0 enable", 32'(en[0]), 32'h1);
    // A configuration write clears the valid bit but keeps the flag
    wr(ra(0, rpsec_pkg::OFF_CFG), INTR);
    rd(ra(0, rpsec_pkg::OFF_STATUS), 32'h4);
    repeat (8) @(posedge clk);
    chk("tx left", 32'(tx_q.size()), 32'h0);
    chk("alarms left", 32'(al_q.size()), 32'h0);
    chk("check errors", 32'(cerr_seen), 32'h1);
    stop_test();
  end
endmodule : testbench
